// *** design/aits_consts.vh ***
// Purpose: Offsets, field positions and reset values of the audio IPC shim
// Assumes: 32-bit APB data, byte addresses, one word per register
// Notes:   Mailbox occupies the upper 4 KB of the 8 KB window
`ifndef AITS_CONSTS_VH
`define AITS_CONSTS_VH

`define AITS_ADDR_W        13
`define AITS_DATA_W        32
`define AITS_NUM_SSP       3
`define AITS_NUM_DMA       8
`define AITS_NUM_SRC       12
`define AITS_SRC_SSP_LSB   0
`define AITS_SRC_DMA_LSB   3
`define AITS_SRC_TIMER     11

`define AITS_OFF_DSP_STAT  13'h0000
`define AITS_OFF_DSP_MASK  13'h0004
`define AITS_OFF_HOST_STAT 13'h0008
`define AITS_OFF_HOST_MASK 13'h000c
`define AITS_OFF_H2D_MSG   13'h0010
`define AITS_OFF_D2H_MSG   13'h0014
`define AITS_OFF_P2D_MSG   13'h0018
`define AITS_OFF_D2P_MSG   13'h001c
`define AITS_OFF_MSG_PEND  13'h0020
`define AITS_OFF_MSG_ACK   13'h0024
`define AITS_OFF_MSG_MASK  13'h0028
`define AITS_OFF_TMR_CTRL  13'h002c
`define AITS_OFF_TMR_MATCH 13'h0030
`define AITS_OFF_TMR_COUNT 13'h0034
`define AITS_MBOX_SEL_BIT  12
`define AITS_MBOX_WORDS    1024
`define AITS_MBOX_IDX_W    10

`define AITS_NUM_MSG       4
`define AITS_MSG_H2D       0
`define AITS_MSG_D2H       1
`define AITS_MSG_P2D       2
`define AITS_MSG_D2P       3

`define AITS_TMR_RUN       0
`define AITS_TMR_CLEAR     1

`define AITS_RST_MASK      12'h000
`define AITS_RST_MSG_MASK  4'h0
`define AITS_RST_WORD      32'h00000000
`define AITS_RST_TMR_CTRL  2'h0

`endif

// *** design/aits_shim.v ***
// Purpose: Audio IPC shim: interrupt routing, doorbell messages, mailbox, match timer
// Assumes: All sources and APB on core_clk; ssp_src_clk is an asynchronous pin
// Notes:   Timer counts on rising edges of the sampled serial-port source clock
//
// What this block does
// - Each serial audio port contributes exactly one interrupt source bit.
// - Each DMA channel has its own separate interrupt input and status bit.
// - All peripheral sources feed the DSP-side interrupt status path.
// - The same sources feed the host-side status and host router line.
// - DSP and host destinations each have their own enable mask.
// - Host write of host-to-DSP message interrupts DSP; DSP reads same register.
// - DSP write of DSP-to-host message interrupts host; host reads it back.
// - DSP-to-host message interrupt has its own dedicated host router line.
// - Power controller and DSP notify each other through similar message registers.
// - A 4 KB mailbox is freely readable and writable by every party.
// - Timer counts on the serial-port source clock ahead of the divider.
// - Timer counts only while run is set and clear is low.
// - Timer pulses an interrupt when counter equals the match value.
// - A zero match value never produces a timer interrupt.
// - Counter is 32 bits, free running, wrapping to zero after all ones.
// - Clearing run stops the counter and holds its value.
// - Clear forces the counter to zero; software clears it to restart.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "aits_consts.vh"

module aits_shim (
    input  wire                          core_clk,
    input  wire                          rst_n,
    input  wire                          psel,
    input  wire                          penable,
    input  wire                          pwrite,
    input  wire [`AITS_ADDR_W-1:0]       paddr,
    input  wire [`AITS_DATA_W-1:0]       pwdata,
    output wire [`AITS_DATA_W-1:0]       prdata,
    output wire                          pready,
    output wire                          pslverr,
    input  wire [`AITS_NUM_SSP-1:0]      serial_audio_port_irq,
    input  wire [`AITS_NUM_DMA-1:0]      dma_channel_irq,
    input  wire                          ssp_src_clk,
    output wire                          dsp_irq,
    output wire                          host_periph_irq,
    output wire                          host_msg_irq,
    output wire                          pmc_irq,
    output wire                          timer_match_pulse
);

    // Assert at once, release on a clock edge to avoid recovery races
    // Everything below except the mailbox resets from this copy
    reg        rst_sync1_q;
    reg        rst_sync2_q;
    wire       rst_n_i;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign rst_n_i = rst_sync2_q;

    // APB decode
    wire                        setup_ph;
    wire                        acc_ph;
    wire                        wr_acc;
    wire                        rd_acc;
    wire                        mbox_hit;
    wire [`AITS_MBOX_IDX_W-1:0] mbox_idx;
    reg                         reg_hit;
    reg [31:0]                  prdata_q;

    assign setup_ph = psel & ~penable;
    assign acc_ph   = psel & penable;
    assign wr_acc   = acc_ph & pwrite;
    assign rd_acc   = acc_ph & ~pwrite;
    assign mbox_hit = paddr[`AITS_MBOX_SEL_BIT];
    assign mbox_idx = paddr[`AITS_MBOX_IDX_W+1:2];

    always @* begin
        case (paddr)
            `AITS_OFF_DSP_STAT, `AITS_OFF_DSP_MASK, `AITS_OFF_HOST_STAT,
            `AITS_OFF_HOST_MASK, `AITS_OFF_H2D_MSG, `AITS_OFF_D2H_MSG,
            `AITS_OFF_P2D_MSG, `AITS_OFF_D2P_MSG, `AITS_OFF_MSG_PEND,
            `AITS_OFF_MSG_ACK, `AITS_OFF_MSG_MASK, `AITS_OFF_TMR_CTRL,
            `AITS_OFF_TMR_MATCH, `AITS_OFF_TMR_COUNT: reg_hit = 1'b1;
            default:                                  reg_hit = 1'b0;
        endcase
    end

    // Zero wait states: read data is prepared in the setup cycle
    assign pready  = 1'b1;
    // Mailbox never refuses; only holes in the register page do
    assign pslverr = acc_ph & ~mbox_hit & ~reg_hit;

    // Access-phase strobes of one register, mailbox excluded
    function wr_to;
        input [`AITS_ADDR_W-1:0] off;
        begin
            wr_to = wr_acc & ~mbox_hit & (paddr == off);
        end
    endfunction

    function rd_of;
        input [`AITS_ADDR_W-1:0] off;
        begin
            rd_of = rd_acc & ~mbox_hit & (paddr == off);
        end
    endfunction

    // Software registers
    // Message words keep their content after the doorbell is acked
    reg [`AITS_NUM_SRC-1:0]  dsp_mask_q;
    reg [`AITS_NUM_SRC-1:0]  host_mask_q;
    reg [`AITS_NUM_MSG-1:0]  msg_mask_q;
    reg [1:0]                tmr_ctrl_q;
    reg [31:0]               tmr_match_q;
    reg [31:0]               host_to_dsp_message_q;
    reg [31:0]               dsp_to_host_message_q;
    reg [31:0]               pmc_to_dsp_message_q;
    reg [31:0]               dsp_to_pmc_message_q;

    always @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dsp_mask_q            <= `AITS_RST_MASK;
            host_mask_q           <= `AITS_RST_MASK;
            msg_mask_q            <= `AITS_RST_MSG_MASK;
            tmr_ctrl_q            <= `AITS_RST_TMR_CTRL;
            tmr_match_q           <= `AITS_RST_WORD;
            host_to_dsp_message_q <= `AITS_RST_WORD;
            dsp_to_host_message_q <= `AITS_RST_WORD;
            pmc_to_dsp_message_q  <= `AITS_RST_WORD;
            dsp_to_pmc_message_q  <= `AITS_RST_WORD;
        end else begin
            if (wr_to(`AITS_OFF_DSP_MASK))
                dsp_mask_q <= pwdata[`AITS_NUM_SRC-1:0];
            if (wr_to(`AITS_OFF_HOST_MASK))
                host_mask_q <= pwdata[`AITS_NUM_SRC-1:0];
            if (wr_to(`AITS_OFF_MSG_MASK))
                msg_mask_q <= pwdata[`AITS_NUM_MSG-1:0];
            if (wr_to(`AITS_OFF_TMR_CTRL))
                tmr_ctrl_q <= pwdata[1:0];
            if (wr_to(`AITS_OFF_TMR_MATCH))
                tmr_match_q <= pwdata;
            if (wr_to(`AITS_OFF_H2D_MSG))
                host_to_dsp_message_q <= pwdata;
            if (wr_to(`AITS_OFF_D2H_MSG))
                dsp_to_host_message_q <= pwdata;
            if (wr_to(`AITS_OFF_P2D_MSG))
                pmc_to_dsp_message_q <= pwdata;
            if (wr_to(`AITS_OFF_D2P_MSG))
                dsp_to_pmc_message_q <= pwdata;
        end
    end

    // Doorbell pending bits; a ring in the ack cycle keeps the bit set
    reg  [`AITS_NUM_MSG-1:0] msg_pend_q;
    wire [`AITS_NUM_MSG-1:0] msg_ring;
    wire [`AITS_NUM_MSG-1:0] msg_ack;

    assign msg_ring[`AITS_MSG_H2D] = wr_to(`AITS_OFF_H2D_MSG);
    assign msg_ring[`AITS_MSG_D2H] = wr_to(`AITS_OFF_D2H_MSG);
    assign msg_ring[`AITS_MSG_P2D] = wr_to(`AITS_OFF_P2D_MSG);
    assign msg_ring[`AITS_MSG_D2P] = wr_to(`AITS_OFF_D2P_MSG);
    // Write one to acknowledge; zero bits leave other doorbells alone
    assign msg_ack = wr_to(`AITS_OFF_MSG_ACK) ? pwdata[`AITS_NUM_MSG-1:0]
                                                : {`AITS_NUM_MSG{1'b0}};

    always @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i)
            msg_pend_q <= {`AITS_NUM_MSG{1'b0}};
        else
            msg_pend_q <= (msg_pend_q & ~msg_ack) | msg_ring;
    end

    // Serial-port source clock: two flops, then edge detect
    reg  src_clk_s1_q;
    reg  src_clk_s2_q;
    reg  src_clk_s3_q;
    wire tmr_tick;

    always @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_clk_s1_q <= 1'b0;
            src_clk_s2_q <= 1'b0;
            src_clk_s3_q <= 1'b0;
        end else begin
            src_clk_s1_q <= ssp_src_clk;
            src_clk_s2_q <= src_clk_s1_q;
            src_clk_s3_q <= src_clk_s2_q;
        end
    end
    // One enable per source-clock period; 25 MHz max against 50 MHz core
    // Flops reset to the idle low level, so no false tick after reset
    assign tmr_tick = src_clk_s2_q & ~src_clk_s3_q;

    // Match timer
    reg  [31:0] tmr_cnt_q;
    reg  [31:0] tmr_cnt_d;
    reg         tmr_hit_q;
    wire        tmr_run;
    wire        tmr_clr;
    wire        tmr_match_hit;

    assign tmr_run = tmr_ctrl_q[`AITS_TMR_RUN];
    assign tmr_clr = tmr_ctrl_q[`AITS_TMR_CLEAR];

    // Clear wins over run so software can zero a running counter
    always @* begin
        tmr_cnt_d = tmr_cnt_q;
        if (tmr_clr)
            tmr_cnt_d = 32'h00000000;
        else if (tmr_run && tmr_tick)
            tmr_cnt_d = tmr_cnt_q + 32'h00000001;
    end

    // Fires once per tick on which the new count meets the match
    assign tmr_match_hit = tmr_run & ~tmr_clr & tmr_tick
                           & (tmr_cnt_d == tmr_match_q)
                           & (tmr_match_q != 32'h00000000);

    always @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_cnt_q <= 32'h00000000;
            tmr_hit_q <= 1'b0;
        end else begin
            tmr_cnt_q <= tmr_cnt_d;
            tmr_hit_q <= tmr_match_hit;
        end
    end
    assign timer_match_pulse = tmr_hit_q;

    // Interrupt sources, one bit each
    wire [`AITS_NUM_SRC-1:0] src_vec;

    // Layout: serial ports low, then DMA channels, timer on top
    assign src_vec = {tmr_hit_q,
                      dma_channel_irq,
                      serial_audio_port_irq};

    // Two status copies so each destination clears only its own view
    reg  [`AITS_NUM_SRC-1:0] dsp_stat_q;
    reg  [`AITS_NUM_SRC-1:0] host_stat_q;
    wire                     dsp_stat_rd;
    wire                     host_stat_rd;
    wire [`AITS_NUM_SRC-1:0] dsp_stat_clr;
    wire [`AITS_NUM_SRC-1:0] host_stat_clr;

    assign dsp_stat_rd  = rd_of(`AITS_OFF_DSP_STAT);
    assign host_stat_rd = rd_of(`AITS_OFF_HOST_STAT);

    // Clear only what the read returned; a bit set after capture survives
    assign dsp_stat_clr  = dsp_stat_rd ? prdata_q[`AITS_NUM_SRC-1:0] : {`AITS_NUM_SRC{1'b0}};
    assign host_stat_clr = host_stat_rd ? prdata_q[`AITS_NUM_SRC-1:0] : {`AITS_NUM_SRC{1'b0}};

    genvar gi;
    generate
        for (gi = 0; gi < `AITS_NUM_SRC; gi = gi + 1) begin : g_src
            // Sticky bits; a source active during the clearing read wins
            always @(posedge core_clk or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    dsp_stat_q[gi]  <= 1'b0;
                    host_stat_q[gi] <= 1'b0;
                end else begin
                    dsp_stat_q[gi]  <= src_vec[gi] | (dsp_stat_q[gi] & ~dsp_stat_clr[gi]);
                    host_stat_q[gi] <= src_vec[gi] | (host_stat_q[gi] & ~host_stat_clr[gi]);
                end
            end
        end
    endgenerate

    // Level outputs, high while any enabled bit stays pending
    // Doorbells toward the DSP share its line with the peripherals
    assign dsp_irq = |(dsp_stat_q & dsp_mask_q)
                     | (msg_pend_q[`AITS_MSG_H2D] & msg_mask_q[`AITS_MSG_H2D])
                     | (msg_pend_q[`AITS_MSG_P2D] & msg_mask_q[`AITS_MSG_P2D]);
    assign host_periph_irq = |(host_stat_q & host_mask_q);
    assign host_msg_irq = msg_pend_q[`AITS_MSG_D2H] & msg_mask_q[`AITS_MSG_D2H];
    assign pmc_irq = msg_pend_q[`AITS_MSG_D2P] & msg_mask_q[`AITS_MSG_D2P];

    // Mailbox: no layout imposed, any party may read or write any word
    // Read port registered in setup so the array can map onto block RAM
    reg [31:0] mbox_mem [0:`AITS_MBOX_WORDS-1];
    reg [31:0] mbox_rd_q;

    always @(posedge core_clk) begin
        if (wr_acc && mbox_hit)
            mbox_mem[mbox_idx] <= pwdata;
        if (setup_ph && mbox_hit)
            mbox_rd_q <= mbox_mem[mbox_idx];
    end

    // Register read mux, registered in the setup cycle
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        case (paddr)
            `AITS_OFF_DSP_STAT:  rd_mux[`AITS_NUM_SRC-1:0] = dsp_stat_q;
            `AITS_OFF_DSP_MASK:  rd_mux[`AITS_NUM_SRC-1:0] = dsp_mask_q;
            `AITS_OFF_HOST_STAT: rd_mux[`AITS_NUM_SRC-1:0] = host_stat_q;
            `AITS_OFF_HOST_MASK: rd_mux[`AITS_NUM_SRC-1:0] = host_mask_q;
            `AITS_OFF_H2D_MSG:   rd_mux = host_to_dsp_message_q;
            `AITS_OFF_D2H_MSG:   rd_mux = dsp_to_host_message_q;
            `AITS_OFF_P2D_MSG:   rd_mux = pmc_to_dsp_message_q;
            `AITS_OFF_D2P_MSG:   rd_mux = dsp_to_pmc_message_q;
            `AITS_OFF_MSG_PEND:  rd_mux[`AITS_NUM_MSG-1:0] = msg_pend_q;
            `AITS_OFF_MSG_MASK:  rd_mux[`AITS_NUM_MSG-1:0] = msg_mask_q;
            `AITS_OFF_TMR_CTRL:  rd_mux[1:0] = tmr_ctrl_q;
            `AITS_OFF_TMR_MATCH: rd_mux = tmr_match_q;
            `AITS_OFF_TMR_COUNT: rd_mux = tmr_cnt_q;
            default:             rd_mux = 32'h00000000;
        endcase
    end

    // Captured at setup; a status read clears only the bits captured here,
    // so an event arriving in the same cycle is reported by the next read
    always @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i)
            prdata_q <= 32'h00000000;
        else if (setup_ph && !pwrite && !mbox_hit)
            prdata_q <= rd_mux;
    end

    reg rd_from_mbox_q;

    always @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i)
            rd_from_mbox_q <= 1'b0;
        else if (setup_ph)
            rd_from_mbox_q <= mbox_hit;
    end

    assign prdata = rd_from_mbox_q ? mbox_rd_q : prdata_q;

endmodule

`default_nettype wire

// *** verif/aits_far_side.sv ***
// Purpose: Far-side model of the serial-port source clock
// Assumes: Clock stands low while go is low
// Notes:   Counts the rising edges it has made
`timescale 1ns/1ns
`default_nettype none
module aits_far_side (
    input  wire logic go,
    output var  logic ssp_src_clk,
    output var  int   edge_cnt
);
    initial begin
        ssp_src_clk = 1'b0;
        edge_cnt = 0;
        forever begin
            wait (go);
            #26 ssp_src_clk = 1'b1;
            edge_cnt++;
            #26 ssp_src_clk = 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** verif/aits_shim_properties.sv ***
// Purpose: Port-level checks of the audio IPC shim
// Assumes: Message lines follow pending and mask within two edges
// Notes:   Bound onto every shim instance
`timescale 1ns/1ns
`default_nettype none
`include "aits_consts.vh"
module aits_shim_properties (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [12:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        host_msg_irq,
    input wire logic        pmc_irq,
    input wire logic        timer_match_pulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire acc = psel && penable;
    wire wr  = acc && pwrite;
    wire msk = wr && paddr == `AITS_OFF_MSG_MASK;
    wire ack = wr && paddr == `AITS_OFF_MSG_ACK;
    wire d2h = msk || (wr && paddr == `AITS_OFF_D2H_MSG);
    wire d2p = msk || (wr && paddr == `AITS_OFF_D2P_MSG);
    wire clr = ack || msk;
    wire ack_rd = acc && !pwrite && paddr == `AITS_OFF_MSG_ACK;
    wire msg_reg = acc && paddr >= `AITS_OFF_H2D_MSG && paddr <= `AITS_OFF_D2P_MSG;
    chk_d2h_rise: assert property ($rose(host_msg_irq) |-> $past(d2h) || $past(d2h, 2))
        else $error("host message line rose without cause");
    chk_d2p_rise: assert property ($rose(pmc_irq) |-> $past(d2p) || $past(d2p, 2))
        else $error("power line rose without cause");
    chk_d2h_held: assert property ($fell(host_msg_irq) |-> $past(clr) || $past(clr, 2))
        else $error("host message line dropped before ack");
    chk_d2p_held: assert property ($fell(pmc_irq) |-> $past(clr) || $past(clr, 2))
        else $error("power line dropped before ack");
    chk_pulse_single: assert property (timer_match_pulse |=> !timer_match_pulse)
        else $error("match pulse longer than one cycle");
    chk_mbox_no_err: assert property (acc && paddr[12] |-> !pslverr)
        else $error("mailbox access refused");
    chk_ack_reads_zero: assert property (ack_rd |-> prdata == 32'h0)
        else $error("ack register read nonzero");
    chk_msg_regs_ok: assert property (msg_reg |-> !pslverr)
        else $error("message register refused");
    cover property ($rose(host_msg_irq));
    cover property (timer_match_pulse);
    cover property (acc && pslverr);
endmodule
bind aits_shim aits_shim_properties aits_shim_properties_i (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pslverr(pslverr), .host_msg_irq(host_msg_irq), .pmc_irq(pmc_irq),
    .timer_match_pulse(timer_match_pulse));
`default_nettype wire

// *** verif/aits_shim_bench.sv ***
// Purpose: Self-checking bench for the audio IPC shim
// Assumes: Zero-wait APB, sources sampled as levels
// Notes:   A monitor drains read notes from a queue
`timescale 1ns/1ns
`default_nettype none
`include "aits_consts.vh"
module aits_shim_bench;
    logic        core_clk, rst_n, psel, penable, pwrite, go, pready, pslverr;
    logic        dsp_irq, hp_irq, hm_irq, pmc_irq, tpulse, sclk;
    logic [12:0] paddr;
    logic [31:0] pwdata, prdata, m, d;
    logic [2:0]  sap_irq;
    logic [7:0]  dma_irq;
    logic [45:0] notes[$];
    logic [45:0] n;
    int          num_errors, n_compared, pulses, ec, base;
    logic [3:0]  line_of[4] = '{4'b0001, 4'b0100, 4'b0001, 4'b1000};
    logic [12:0] msg_off[4] = '{13'h10, 13'h14, 13'h18, 13'h1c};
    aits_shim aits_shim_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_audio_port_irq(sap_irq), .dma_channel_irq(dma_irq),
        .ssp_src_clk(sclk), .dsp_irq(dsp_irq), .host_periph_irq(hp_irq),
        .host_msg_irq(hm_irq), .pmc_irq(pmc_irq), .timer_match_pulse(tpulse));
    aits_far_side aits_far_side_i (.go(go), .ssp_src_clk(sclk), .edge_cnt(ec));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [12:0] a, input logic [31:0] e, input logic err);
        notes.push_back({err, a, e});
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic settle;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    // Clock stops between bursts so the count is exact
    task automatic run_src(input int k);
        base = ec;
        go <= 1'b1;
        for (int t = 0; t < 2000 && ec < base + k; t++) @(posedge core_clk);
        go <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (tpulse === 1'b1) pulses++;
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
            n = notes.pop_front();
            chk($sformatf("read %h", n[44:32]), n[31:0], prdata);
            chk($sformatf("error %h", n[44:32]), {31'h0, n[45]}, {31'h0, pslverr});
        end
    end
    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {rst_n, psel, penable, pwrite, go, paddr, pwdata, sap_irq, dma_irq} = '0;
        void'($urandom(32'h752a));
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(`AITS_OFF_DSP_MASK, 0, 0);
        rd(`AITS_OFF_HOST_MASK, 0, 0);
        rd(`AITS_OFF_TMR_CTRL, 0, 0);
        rd(13'h0100, 0, 1);
        $display("test reset_values done");
        for (int i = 0; i < 11; i++) begin
            m = $urandom & 32'h7ff;
            xfer(1, `AITS_OFF_DSP_MASK, m);
            xfer(1, `AITS_OFF_HOST_MASK, ~m & 32'h7ff);
            {dma_irq, sap_irq} <= 11'h1 << i;
            @(posedge core_clk);
            {dma_irq, sap_irq} <= 11'h0;
            settle();
            chk("irq pair", {30'h0, ~m[i], m[i]}, {30'h0, hp_irq, dsp_irq});
            rd(`AITS_OFF_DSP_STAT, 32'h1 << i, 0);
            rd(`AITS_OFF_HOST_STAT, 32'h1 << i, 0);
            settle();
            chk("irq idle", 0, {30'h0, hp_irq, dsp_irq});
        end
        $display("test routing done");
        for (int k = 0; k < 4; k++) begin
            d = $urandom;
            xfer(1, `AITS_OFF_MSG_MASK, 0);
            xfer(1, msg_off[k], d);
            settle();
            chk("masked lines", 0, {pmc_irq, hm_irq, hp_irq, dsp_irq});
            xfer(1, `AITS_OFF_MSG_MASK, 32'hf);
            settle();
            chk("message lines", line_of[k], {pmc_irq, hm_irq, hp_irq, dsp_irq});
            rd(msg_off[k], d, 0);
            rd(`AITS_OFF_MSG_PEND, 32'h1 << k, 0);
            xfer(1, `AITS_OFF_MSG_ACK, 32'h1 << k);
            settle();
            chk("acked lines", 0, {pmc_irq, hm_irq, hp_irq, dsp_irq});
            rd(`AITS_OFF_MSG_PEND, 0, 0);
        end
        rd(`AITS_OFF_MSG_ACK, 0, 0);
        $display("test doorbells done");
        d = $urandom;
        xfer(1, 13'h1000, d);
        xfer(1, 13'h1ffc, ~d);
        rd(13'h1000, d, 0);
        rd(13'h1ffc, ~d, 0);
        $display("test mailbox done");
        xfer(1, `AITS_OFF_TMR_MATCH, 5);
        xfer(1, `AITS_OFF_TMR_CTRL, 2);
        xfer(1, `AITS_OFF_TMR_CTRL, 1);
        pulses = 0;
        run_src(10);
        rd(`AITS_OFF_TMR_COUNT, 10, 0);
        chk("match pulses", 1, pulses);
        rd(`AITS_OFF_DSP_STAT, 32'h800, 0);
        xfer(1, `AITS_OFF_TMR_CTRL, 0);
        run_src(3);
        rd(`AITS_OFF_TMR_COUNT, 10, 0);
        xfer(1, `AITS_OFF_TMR_CTRL, 3);
        run_src(3);
        rd(`AITS_OFF_TMR_COUNT, 0, 0);
        xfer(1, `AITS_OFF_TMR_MATCH, 0);
        xfer(1, `AITS_OFF_TMR_CTRL, 1);
        run_src(6);
        rd(`AITS_OFF_TMR_COUNT, 6, 0);
        chk("zero match pulses", 1, pulses);
        $display("test timer done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
